// File: design/etxf_mem.sv
`timescale 1ns/10ps
`default_nettype none

// fifo storage: one write port, one read port, read data from a register
module etxf_mem #(
  parameter int DEPTH = etxf_pkg::FIFO_DEPTH_DEF,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic clk_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [etxf_pkg::DATA_W-1:0] wr_data_i,
  // read side
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [etxf_pkg::DATA_W-1:0] rd_data_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // storage array, no reset needed
  logic [etxf_pkg::DATA_W-1:0] mem [DEPTH];
  logic [etxf_pkg::DATA_W-1:0] rd_data_q; // registered read data

  // write port
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read port, data stand one cycle after the enable
  always_ff @(posedge clk_i)
  begin
    if (rd_en_i)
    begin
      rd_data_q <= mem[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_q;

endmodule : etxf_mem

`default_nettype wire

// File: design/etxf_pkg.sv
package etxf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] REG_DMA_MODE = 8'h00; // dma_mode_register
  localparam logic [7:0] REG_TX_REQ = 8'h04; // transmit_request_register
  localparam logic [7:0] REG_FRAME_LEN = 8'h08; // frame length of the current frame
  localparam logic [7:0] REG_STATUS = 8'h0c; // status flags
  localparam logic [7:0] REG_POINTERS = 8'h10; // write and read pointers

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SOFT_RESET_BIT = 0; // soft_reset_bit in dma_mode_register
  localparam int TX_REQ_BIT = 0; // transmit_request_bit
  localparam int ST_UNDERFLOW_BIT = 0; // sticky underflow, write one to clear
  localparam int ST_STALLED_BIT = 1; // engine stalled with a full fifo
  localparam int ST_ACTIVE_BIT = 2; // descriptor_active_flag
  localparam int ST_WAIT_EMPTY_BIT = 3; // engine waiting for the fifo to empty
  localparam int PTR_RP_LSB = 16; // read pointer field in the pointer register

  ////////////////////////////////////////////////////////////////////////////////
  // sizes and reset values
  localparam int FIFO_DEPTH_DEF = 256; // default fifo_depth_setting in bytes
  localparam int MAX_FRAME_LEN = 1518; // longest frame in bytes
  localparam int LEN_W = 16; // width of frame length and byte counters
  localparam int DATA_W = 8; // one byte per fifo entry
  localparam logic [LEN_W-1:0] FRAME_LEN_RST = 16'h05ee; // 1518 after reset
  localparam logic [31:0] RDATA_RST = 32'h0000_0000; // read data after reset

  ////////////////////////////////////////////////////////////////////////////////
  // transmit engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MOVE,
    ST_WAIT_EMPTY,
    ST_WRITEBACK,
    ST_FETCH
  } etxf_state_e;

endpackage : etxf_pkg

// File: design/etxf_top.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module etxf_top #(
  parameter int DEPTH = etxf_pkg::FIFO_DEPTH_DEF, // fifo_depth_setting, power of two
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // dma write side
  input wire logic bus_grant_i,
  input wire logic dma_wvalid_i,
  input wire logic [etxf_pkg::DATA_W-1:0] dma_wdata_i,
  output logic dma_wready_o,
  // mac read side
  input wire logic mac_rd_i,
  output logic mac_avail_o,
  output logic mac_rvalid_o,
  output logic [etxf_pkg::DATA_W-1:0] mac_rdata_o,
  // descriptor and status
  output logic desc_active_o,
  output logic desc_writeback_o,
  output logic desc_fetch_o,
  output logic underflow_o,
  output logic stalled_o,
  output logic mac_soft_reset_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // constants at the widths they meet
  localparam logic [AW-1:0] PTR_MIN = '0; // write pointer start
  localparam logic [AW-1:0] PTR_MAX = AW'(DEPTH - 1); // read pointer start
  localparam logic [AW:0] LVL_FULL = (AW+1)'(DEPTH); // fifo full level
  localparam logic [AW:0] LVL_ZERO = '0; // fifo empty level

  // whole state of the block
  typedef struct packed {
    etxf_pkg::etxf_state_e st; // engine state
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer, last position read
    logic [AW:0] level; // bytes stored
    logic [etxf_pkg::LEN_W-1:0] len; // frame length
    logic [etxf_pkg::LEN_W-1:0] wr_cnt; // bytes of the frame written
    logic [etxf_pkg::LEN_W-1:0] rd_cnt; // bytes of the frame read
    logic tr; // transmit_request_bit
    logic uf_flag; // sticky underflow status
    logic uf_frame; // current frame underflowed, reading ended
    logic rvalid; // read data valid toward the mac
    logic wb; // write-back pulse
    logic fetch; // fetch pulse
    logic mac_rst; // mac reset pulse
    logic [31:0] rdata; // register read data
  } etxf_state_s;

  etxf_state_s s_q; // registered state
  etxf_state_s s_d; // next state

  // handshake terms
  logic wr_ok; // dma may write this cycle
  logic wr_fire; // byte written
  logic rd_ok; // mac may read this cycle
  logic rd_fire; // byte read
  logic uf_event; // pointers met before the frame was written
  logic [AW:0] lvl_nx; // level after this cycle's moves
  logic [etxf_pkg::LEN_W-1:0] wr_cnt_nx; // written count after this cycle
  logic [etxf_pkg::LEN_W-1:0] rd_cnt_nx; // read count after this cycle
  logic [etxf_pkg::DATA_W-1:0] mem_rdata; // memory read data

  ////////////////////////////////////////////////////////////////////////////////
  // state after reset or soft reset
  function automatic etxf_state_s init_state();
    etxf_state_s r;
    r = '0;
    r.st = etxf_pkg::ST_IDLE;
    r.wp = PTR_MIN;
    r.rp = PTR_MAX;
    r.level = LVL_ZERO;
    r.len = etxf_pkg::FRAME_LEN_RST;
    r.rdata = etxf_pkg::RDATA_RST;
    return r;
  endfunction : init_state

  ////////////////////////////////////////////////////////////////////////////////
  // write side: stalls while bus is lost, fifo is full or draining
  always_comb
  begin
    wr_ok = (s_q.st == etxf_pkg::ST_MOVE) && bus_grant_i && (s_q.wr_cnt < s_q.len) &&
            (s_q.level != LVL_FULL);
    wr_fire = wr_ok && dma_wvalid_i;
  end

  // read side: ended for the rest of the frame after an underflow
  always_comb
  begin
    rd_ok = ((s_q.st == etxf_pkg::ST_MOVE) || (s_q.st == etxf_pkg::ST_WAIT_EMPTY)) &&
            !s_q.uf_frame && (s_q.level != LVL_ZERO) && (s_q.rd_cnt < s_q.len);
    rd_fire = rd_ok && mac_rd_i;
    uf_event = mac_rd_i && (s_q.st == etxf_pkg::ST_MOVE) && !s_q.uf_frame &&
               (s_q.level == LVL_ZERO) && (s_q.wr_cnt < s_q.len);
  end

  // counts after this cycle
  always_comb
  begin
    lvl_nx = s_q.level + (AW+1)'(wr_fire) - (AW+1)'(rd_fire);
    wr_cnt_nx = s_q.wr_cnt + etxf_pkg::LEN_W'(wr_fire);
    rd_cnt_nx = s_q.rd_cnt + etxf_pkg::LEN_W'(rd_fire);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = rd_fire;
    s_d.wb = 1'b0;
    s_d.fetch = 1'b0;
    s_d.mac_rst = 1'b0;
    // pointers move with each byte
    if (wr_fire)
    begin
      s_d.wp = s_q.wp + AW'(1);
    end
    if (rd_fire)
    begin
      s_d.rp = s_q.rp + AW'(1);
    end
    s_d.level = lvl_nx;
    s_d.wr_cnt = wr_cnt_nx;
    s_d.rd_cnt = rd_cnt_nx;
    // underflow: reading ends, read pointer back to its start
    if (uf_event)
    begin
      s_d.uf_frame = 1'b1;
      s_d.rp = PTR_MAX;
      // room left is now the gap from the write pointer to the read start
      s_d.level = {1'b0, s_q.wp} + (AW+1)'(wr_fire);
    end
    // engine sequence
    case (s_q.st)
      etxf_pkg::ST_IDLE:
      begin
        // a new frame starts only from an empty, fully read fifo
        if (s_q.tr)
        begin
          s_d.st = etxf_pkg::ST_MOVE;
          s_d.wr_cnt = '0;
          s_d.rd_cnt = '0;
        end
      end
      etxf_pkg::ST_MOVE:
      begin
        if (wr_cnt_nx == s_q.len && (rd_cnt_nx == s_q.len || s_d.uf_frame))
        begin
          s_d.st = etxf_pkg::ST_WRITEBACK;
        end
        else if (s_d.uf_frame && s_d.level == LVL_FULL && wr_cnt_nx < s_q.len)
        begin
          // full after underflow: wait for an empty that no reader brings
          s_d.st = etxf_pkg::ST_WAIT_EMPTY;
        end
      end
      etxf_pkg::ST_WAIT_EMPTY:
      begin
        if (s_q.level == LVL_ZERO)
        begin
          s_d.st = etxf_pkg::ST_MOVE;
        end
      end
      etxf_pkg::ST_WRITEBACK:
      begin
        s_d.wb = 1'b1;
        s_d.st = etxf_pkg::ST_FETCH;
      end
      etxf_pkg::ST_FETCH:
      begin
        s_d.fetch = 1'b1;
        s_d.tr = 1'b0;
        s_d.uf_frame = 1'b0;
        s_d.st = etxf_pkg::ST_IDLE;
        // leftovers of an underflowed frame are dropped
        if (s_q.uf_frame)
        begin
          s_d.wp = PTR_MIN;
          s_d.rp = PTR_MAX;
          s_d.level = LVL_ZERO;
        end
      end
      default:
      begin
        s_d.st = etxf_pkg::ST_IDLE;
      end
    endcase
    // sticky underflow: a new event wins over the clear
    if (reg_we_i && reg_addr_i == etxf_pkg::REG_STATUS &&
        reg_wdata_i[etxf_pkg::ST_UNDERFLOW_BIT])
    begin
      s_d.uf_flag = 1'b0;
    end
    if (uf_event)
    begin
      s_d.uf_flag = 1'b1;
    end
    // register writes
    if (reg_we_i)
    begin
      case (reg_addr_i)
        etxf_pkg::REG_TX_REQ:
        begin
          // request taken only between frames
          if (reg_wdata_i[etxf_pkg::TX_REQ_BIT] && s_q.st == etxf_pkg::ST_IDLE)
          begin
            s_d.tr = 1'b1;
          end
        end
        etxf_pkg::REG_FRAME_LEN:
        begin
          if (s_q.st == etxf_pkg::ST_IDLE)
          begin
            s_d.len = reg_wdata_i[etxf_pkg::LEN_W-1:0];
          end
        end
        default:
        begin
          s_d.len = s_d.len;
        end
      endcase
    end
    // register reads, data in the following cycle only
    s_d.rdata = '0;
    if (reg_re_i)
    begin
      case (reg_addr_i)
        etxf_pkg::REG_TX_REQ:
        begin
          s_d.rdata[etxf_pkg::TX_REQ_BIT] = s_q.tr;
        end
        etxf_pkg::REG_FRAME_LEN:
        begin
          s_d.rdata[etxf_pkg::LEN_W-1:0] = s_q.len;
        end
        etxf_pkg::REG_STATUS:
        begin
          s_d.rdata[etxf_pkg::ST_UNDERFLOW_BIT] = s_q.uf_flag;
          s_d.rdata[etxf_pkg::ST_STALLED_BIT] = stalled_o;
          s_d.rdata[etxf_pkg::ST_ACTIVE_BIT] = s_q.tr;
          s_d.rdata[etxf_pkg::ST_WAIT_EMPTY_BIT] = (s_q.st == etxf_pkg::ST_WAIT_EMPTY);
        end
        etxf_pkg::REG_POINTERS:
        begin
          s_d.rdata[AW-1:0] = s_q.wp;
          s_d.rdata[etxf_pkg::PTR_RP_LSB +: AW] = s_q.rp;
        end
        default:
        begin
          s_d.rdata = '0; // mode register and unmapped read zero
        end
      endcase
    end
    // soft reset: engine, fifo and mac all start over
    if (reg_we_i && reg_addr_i == etxf_pkg::REG_DMA_MODE &&
        reg_wdata_i[etxf_pkg::SOFT_RESET_BIT])
    begin
      s_d = init_state();
      s_d.mac_rst = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= init_state();
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fifo storage
  etxf_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk_i(clk_i),
    .wr_en_i(wr_fire),
    .wr_addr_i(s_q.wp),
    .wr_data_i(dma_wdata_i),
    .rd_en_i(rd_fire),
    .rd_addr_i(s_q.rp + AW'(1)),
    .rd_data_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign dma_wready_o = wr_ok;
  assign mac_avail_o = rd_ok;
  assign mac_rvalid_o = s_q.rvalid;
  assign mac_rdata_o = s_q.rvalid ? mem_rdata : '0;
  assign reg_rdata_o = s_q.rdata;
  assign desc_active_o = s_q.tr;
  assign desc_writeback_o = s_q.wb;
  assign desc_fetch_o = s_q.fetch;
  assign underflow_o = s_q.uf_flag;
  assign stalled_o = (s_q.st == etxf_pkg::ST_WAIT_EMPTY) && s_q.uf_frame;
  assign mac_soft_reset_o = s_q.mac_rst;

endmodule : etxf_top

`default_nettype wire

// File: sim/etxf_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
// mac reader: pulls bytes from the fifo, promptly or with gaps
module etxf_mac_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench control
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic [1:0] gap_i,
  // fifo read side
  input wire logic mac_avail_i,
  input wire logic mac_rvalid_i,
  input wire logic [etxf_pkg::DATA_W-1:0] mac_rdata_i,
  output logic mac_rd_o,
  // observations
  output logic [15:0] got_o,
  output logic bad_o
);
  logic [1:0] wait_q; // idle cycles left before the next request
  // count bytes and check their order
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      got_o <= 16'h0;
      bad_o <= 1'h0;
    end
    else if (mac_rvalid_i)
    begin
      bad_o <= bad_o | (mac_rdata_i !== got_o[7:0]);
      got_o <= got_o + 16'h1;
    end
  end
  // request held until taken, then an optional pause
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_i)
    begin
      mac_rd_o <= 1'h0;
      wait_q <= 2'h0;
    end
    else if (mac_rd_o && mac_avail_i)
    begin
      mac_rd_o <= (gap_i == 2'h0);
      wait_q <= gap_i;
    end
    else if (wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else
      mac_rd_o <= 1'h1;
  end
endmodule : etxf_mac_model
`default_nettype wire

// File: sim/etxf_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the transmit fifo
module etxf_top_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register writes
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  // dma and mac sides
  input wire logic bus_grant_i,
  input wire logic dma_wready_o,
  input wire logic mac_rd_i,
  input wire logic mac_avail_o,
  input wire logic mac_rvalid_o,
  // descriptor and status
  input wire logic desc_active_o,
  input wire logic desc_writeback_o,
  input wire logic desc_fetch_o,
  input wire logic underflow_o,
  input wire logic stalled_o,
  input wire logic mac_soft_reset_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic swr_wr; // soft reset written this cycle
  logic rd_take; // mac read taken this cycle
  assign swr_wr = reg_we_i && reg_addr_i == etxf_pkg::REG_DMA_MODE && reg_wdata_i[0];
  assign rd_take = mac_rd_i && mac_avail_o;
  // write-back then fetch
  sequence s_wb_fetch;
    desc_writeback_o ##1 desc_fetch_o;
  endsequence
  // single-cycle reset pulse to the mac
  sequence s_mac_pulse;
    mac_soft_reset_o ##1 !mac_soft_reset_o;
  endsequence
  a_wb_then_fetch: assert property (desc_writeback_o |-> s_wb_fetch)
    else $error("fetch did not follow write-back");
  a_fetch_has_cause: assert property (desc_fetch_o |-> $past(desc_writeback_o))
    else $error("fetch without write-back");
  a_write_gated: assert property (dma_wready_o |-> bus_grant_i && desc_active_o)
    else $error("fifo write outside an active frame");
  a_read_answer: assert property (rd_take |=> mac_rvalid_o)
    else $error("taken read gave no data");
  a_rvalid_cause: assert property (mac_rvalid_o |-> $past(rd_take))
    else $error("read data without a taken read");
  a_under_ends_read: assert property ($rose(underflow_o) |-> !mac_avail_o && $past(mac_rd_i))
    else $error("underflow without cause or reading goes on");
  a_stall_sticks: assert property (stalled_o && !swr_wr |=> stalled_o)
    else $error("stall left without soft reset");
  a_stall_blocks: assert property (stalled_o |-> !mac_avail_o && !dma_wready_o)
    else $error("traffic while stalled");
  a_swr_pulse: assert property (swr_wr |=> s_mac_pulse)
    else $error("no mac reset pulse after soft reset");
  a_swr_clears: assert property (mac_soft_reset_o |-> !underflow_o && !stalled_o)
    else $error("state not cleared by soft reset");
endmodule : etxf_top_sva
bind etxf_top etxf_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .bus_grant_i(bus_grant_i),
  .dma_wready_o(dma_wready_o), .mac_rd_i(mac_rd_i), .mac_avail_o(mac_avail_o),
  .mac_rvalid_o(mac_rvalid_o), .desc_active_o(desc_active_o),
  .desc_writeback_o(desc_writeback_o), .desc_fetch_o(desc_fetch_o),
  .underflow_o(underflow_o), .stalled_o(stalled_o), .mac_soft_reset_o(mac_soft_reset_o));
`default_nettype wire

// File: sim/test_eth_tx_fifo_underflow_recovery.sv
`timescale 1ns/10ps
`default_nettype none
module test_eth_tx_fifo_underflow_recovery;
  localparam int DEPTH = 16; // small fifo, below the longest frame
  // host supervision of a 100 Mbps link, bench clock 50 ns
  localparam int CLK_NS = 50; // bench clock period
  localparam int PERIOD_CYC = 100; // one fixed supervision period in cycles
  localparam bit HALF_DUPLEX = 1'b0; // link under test is full duplex
  localparam bit FLOW_CTRL = 1'b0; // link under test has no flow control
  localparam int LIM_FD = 130000; // full duplex stall limit in ns
  localparam int LIM_HD = 18300000; // half duplex stall limit in ns
  localparam int LIM_FC = 33600000; // flow control stall limit in ns
  localparam int LIM_NS = FLOW_CTRL ? LIM_FC : (HALF_DUPLEX ? LIM_HD : LIM_FD);
  localparam int N_PERIODS = (LIM_NS / CLK_NS + PERIOD_CYC - 1) / PERIOD_CYC; // limit n
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'h0;
  logic reg_re_i = 1'h0;
  logic bus_grant_i = 1'h1;
  logic dma_wvalid_i = 1'h0;
  logic [7:0] dma_wdata_i = 8'h0;
  logic [31:0] reg_rdata_o;
  logic [7:0] mac_rdata_o;
  logic dma_wready_o, mac_rd_i, mac_avail_o, mac_rvalid_o, desc_active_o;
  logic desc_writeback_o, desc_fetch_o, underflow_o, stalled_o, mac_soft_reset_o;
  logic mac_en = 1'h0; // mac model control
  logic mac_clr = 1'h0;
  logic [1:0] mac_gap = 2'h0;
  logic [15:0] got; // bytes seen by the mac
  logic bad;
  logic [31:0] rd;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  int sent, i, k;
  int wp_m = 0; // pointer model
  int rp_m = DEPTH - 1;
  etxf_top #(.DEPTH(DEPTH)) dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .bus_grant_i(bus_grant_i), .dma_wvalid_i(dma_wvalid_i),
    .dma_wdata_i(dma_wdata_i), .dma_wready_o(dma_wready_o), .mac_rd_i(mac_rd_i),
    .mac_avail_o(mac_avail_o), .mac_rvalid_o(mac_rvalid_o), .mac_rdata_o(mac_rdata_o),
    .desc_active_o(desc_active_o), .desc_writeback_o(desc_writeback_o),
    .desc_fetch_o(desc_fetch_o), .underflow_o(underflow_o), .stalled_o(stalled_o),
    .mac_soft_reset_o(mac_soft_reset_o));
  etxf_mac_model u_mac (.clk_i(clk_i), .rst_i(rst_i), .en_i(mac_en), .clr_i(mac_clr),
    .gap_i(mac_gap), .mac_avail_i(mac_avail_o), .mac_rvalid_i(mac_rvalid_o),
    .mac_rdata_i(mac_rdata_o), .mac_rd_o(mac_rd_i), .got_o(got), .bad_o(bad));
  always #25 clk_i = ~clk_i;
  ////////////////////////////////////////
  // verdict and comparison
  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  // register port cycles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'h1;
    @(posedge clk_i);
    reg_we_i <= 1'h0;
    // one idle edge so a following write never re-drives the strobe in this step
    @(posedge clk_i);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_re_i <= 1'h1;
    @(posedge clk_i);
    reg_re_i <= 1'h0;
    @(posedge clk_i);
    d = reg_rdata_o;
  endtask : reg_rd
  // bounded wait for a level: sel high watches underflow, low the active flag
  task automatic wait_level(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? underflow_o : desc_active_o) !== v && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_level
  // offer bytes from..from+n-1, give up when the fifo stops taking
  task automatic dma_send(input int from, input int n, output int cnt);
    int k;
    cnt = 0;
    for (int b = from; b < from + n; b++)
    begin
      dma_wvalid_i <= 1'h1;
      dma_wdata_i <= 8'(b);
      k = 0;
      do
      begin
        @(posedge clk_i);
        k++;
      end
      while (dma_wready_o !== 1'h1 && k < 30);
      if (dma_wready_o !== 1'h1)
        break;
      cnt++;
    end
    dma_wvalid_i <= 1'h0;
  endtask : dma_send
  // one whole frame: stored first, then read out
  task automatic run_frame(input int len, input logic [1:0] gap);
    reg_rd(etxf_pkg::REG_TX_REQ, rd);
    check("request bit", rd, 32'h0);
    reg_wr(etxf_pkg::REG_FRAME_LEN, 32'(len));
    reg_wr(etxf_pkg::REG_TX_REQ, 32'h1);
    mac_clr <= 1'h1;
    dma_send(0, len, sent);
    mac_clr <= 1'h0;
    check("bytes stored", 32'(sent), 32'(len));
    reg_wr(etxf_pkg::REG_FRAME_LEN, 32'h5);
    reg_rd(etxf_pkg::REG_FRAME_LEN, rd);
    check("length while busy", rd, 32'(len));
    check("write ready after frame", 32'(dma_wready_o), 32'h0);
    mac_gap <= gap;
    mac_en <= 1'h1;
    wait_level(1'h0, 1'h0);
    mac_en <= 1'h0;
    check("bytes read", 32'(got), 32'(len));
    check("byte order", 32'(bad), 32'h0);
    wp_m = (wp_m + len) % DEPTH;
    rp_m = (rp_m + len) % DEPTH;
    reg_rd(etxf_pkg::REG_POINTERS, rd);
    check("pointers after frame", rd, (32'(rp_m) << 16) | 32'(wp_m));
  endtask : run_frame
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    reg_rd(etxf_pkg::REG_POINTERS, rd);
    check("pointers after reset", rd, 32'(DEPTH - 1) << 16);
    reg_rd(etxf_pkg::REG_FRAME_LEN, rd);
    check("frame length after reset", rd, 32'(etxf_pkg::FRAME_LEN_RST));
    reg_rd(8'h40, rd);
    check("unmapped read", rd, 32'h0);
    // bus lost after five bytes of a 30-byte frame
    reg_wr(etxf_pkg::REG_FRAME_LEN, 32'h1e);
    reg_wr(etxf_pkg::REG_TX_REQ, 32'h1);
    dma_send(0, 5, sent);
    bus_grant_i <= 1'h0;
    mac_en <= 1'h1;
    wait_level(1'h1, 1'h1);
    check("underflow flag", 32'(underflow_o), 32'h1);
    check("bytes before underflow", 32'(got), 32'h5);
    reg_rd(etxf_pkg::REG_POINTERS, rd);
    check("pointers at underflow", rd, (32'(DEPTH - 1) << 16) | 32'h5);
    bus_grant_i <= 1'h1;
    dma_send(5, 25, sent);
    check("bytes after underflow", 32'(sent), 32'(DEPTH - 5));
    reg_rd(etxf_pkg::REG_STATUS, rd);
    check("status when stalled", rd, 32'hf);
    reg_wr(etxf_pkg::REG_STATUS, 32'h1);
    reg_rd(etxf_pkg::REG_STATUS, rd);
    check("status after clear", rd, 32'he);
    // host supervision: count periods with the descriptor still active
    i = 0;
    do
    begin
      // a period ends early only when the frame-sent pulse releases the host
      k = 0;
      while (desc_fetch_o !== 1'h1 && k < PERIOD_CYC)
      begin
        @(posedge clk_i);
        k++;
      end
      reg_rd(etxf_pkg::REG_STATUS, rd);
      if (rd[etxf_pkg::ST_ACTIVE_BIT] === 1'h1)
        i++;
    end
    while (rd[etxf_pkg::ST_ACTIVE_BIT] === 1'h1 && i < N_PERIODS);
    check("periods before reset", 32'(i), 32'(N_PERIODS));
    mac_en <= 1'h0;
    reg_wr(etxf_pkg::REG_DMA_MODE, 32'h1);
    reg_rd(etxf_pkg::REG_POINTERS, rd);
    check("pointers after soft reset", rd, 32'(DEPTH - 1) << 16);
    reg_rd(etxf_pkg::REG_STATUS, rd);
    check("status after soft reset", rd, 32'h0);
    // traffic again, prompt then slow reader, full-depth frame last
    run_frame(12, 2'h0);
    run_frame(DEPTH, 2'h2);
    tally_and_finish();
  end
endmodule : test_eth_tx_fifo_underflow_recovery
`default_nettype wire
